// ### core/timer8_pkg.sv
package timer8_pkg;

    // ----------------------------------------------------------------
    // register map, byte addresses on the bus
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTL_A = 8'h30;
    localparam logic [7:0] OFF_CTL_B = 8'h34;
    localparam logic [7:0] OFF_COUNT = 8'h38;
    localparam logic [7:0] OFF_CMP_A = 8'h3C;
    localparam logic [7:0] OFF_CMP_B = 8'h40;
    localparam logic [7:0] OFF_FLAGS = 8'h44;
    localparam logic [7:0] OFF_PORT = 8'h48;

    // ----------------------------------------------------------------
    // reset values and writable-bit masks
    // ----------------------------------------------------------------
    localparam logic [7:0] CTL_A_RST = 8'h00;
    localparam logic [7:0] CTL_B_RST = 8'h00;
    localparam logic [7:0] CTL_A_WMASK = 8'hF3;
    localparam logic [7:0] CTL_B_WMASK = 8'h0F;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int F_ACT_A = 6;
    localparam int F_ACT_B = 4;
    localparam int F_MSB = 3;
    localparam int FLG_OVF = 0;
    localparam int FLG_A = 1;
    localparam int FLG_B = 2;
    localparam int PRT_DIR = 0;
    localparam int PRT_DAT = 2;

    // ----------------------------------------------------------------
    // counter limits and prescaler taps
    // ----------------------------------------------------------------
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam int DIV8_BITS = 3;
    localparam int DIV64_BITS = 6;
    localparam int DIV256_BITS = 8;
    localparam int DIV1024_BITS = 10;

    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0,
        MODE_PC_FF = 3'h1,
        MODE_CTC = 3'h2,
        MODE_FAST_FF = 3'h3,
        MODE_RSV4 = 3'h4,
        MODE_PC_CMP = 3'h5,
        MODE_RSV6 = 3'h6,
        MODE_FAST_CMP = 3'h7
    } wave_mode_e;

    typedef enum logic [1:0] {
        ACT_OFF = 2'h0,
        ACT_TOGGLE = 2'h1,
        ACT_CLEAR = 2'h2,
        ACT_SET = 2'h3
    } out_action_e;

    typedef enum logic [2:0] {
        SRC_STOP = 3'h0,
        SRC_DIV1 = 3'h1,
        SRC_DIV8 = 3'h2,
        SRC_DIV64 = 3'h3,
        SRC_DIV256 = 3'h4,
        SRC_DIV1024 = 3'h5,
        SRC_EXT_FALL = 3'h6,
        SRC_EXT_RISE = 3'h7
    } tick_src_e;

endpackage : timer8_pkg

// ### core/tick_prescaler.sv
`timescale 1ns/10ps
module tick_prescaler #(
    parameter int PRESC_W = 10
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [2:0] tick_source_sel,
    input wire logic ext_tick_pin,
    output logic tick_enable
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (PRESC_W < timer8_pkg::DIV1024_BITS) begin : g_chk
        $error("prescaler too narrow for the divide-by-1024 tap");
    end

    logic [PRESC_W-1:0] presc_reg;
    logic ext_prev_reg;
    logic tick_reg;
    logic tick_next;

    // taps fire once per full wrap of their low bits
    wire div8 = &presc_reg[timer8_pkg::DIV8_BITS-1:0];
    wire div64 = &presc_reg[timer8_pkg::DIV64_BITS-1:0];
    wire div256 = &presc_reg[timer8_pkg::DIV256_BITS-1:0];
    wire div1024 = &presc_reg[timer8_pkg::DIV1024_BITS-1:0];
    wire ext_fall = ext_prev_reg & ~ext_tick_pin;
    wire ext_rise = ~ext_prev_reg & ext_tick_pin;

    // source select, a stopped source never ticks
    always_comb begin
        unique case (timer8_pkg::tick_src_e'(tick_source_sel))
            timer8_pkg::SRC_STOP: tick_next = 1'b0;
            timer8_pkg::SRC_DIV1: tick_next = 1'b1;
            timer8_pkg::SRC_DIV8: tick_next = div8;
            timer8_pkg::SRC_DIV64: tick_next = div64;
            timer8_pkg::SRC_DIV256: tick_next = div256;
            timer8_pkg::SRC_DIV1024: tick_next = div1024;
            timer8_pkg::SRC_EXT_FALL: tick_next = ext_fall;
            timer8_pkg::SRC_EXT_RISE: tick_next = ext_rise;
        endcase
    end

    // prescaler runs free so switching taps keeps a steady phase
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            presc_reg <= '0;
            ext_prev_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            presc_reg <= presc_reg + 1'b1;
            ext_prev_reg <= ext_tick_pin;
            tick_reg <= tick_next;
        end
    end

    assign tick_enable = tick_reg;

endmodule : tick_prescaler

// ### core/timer8_waveform_mode_control.sv
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps
module timer8_waveform_mode_control #(
    parameter int PRESC_W = 10
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic ext_tick_pin,
    input wire logic vec_ack_ovf,
    input wire logic vec_ack_a,
    input wire logic vec_ack_b,
    output logic overflow_flag,
    output logic match_flag_a,
    output logic match_flag_b,
    output logic wave_out_a,
    output logic wave_out_b,
    output logic pin_a_out,
    output logic pin_a_oe,
    output logic pin_b_out,
    output logic pin_b_oe
);

    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    logic [7:0] ctl_a_reg;
    logic [7:0] ctl_b_reg;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic down_reg;
    logic down_next;
    logic block_reg;
    logic [2:0] flags_reg;
    logic [2:0] flags_next;
    logic [3:0] port_reg;
    logic waitreq_reg;
    logic [31:0] readdata_reg;
    logic [7:0] cmp_buf_reg [2];
    logic [7:0] cmp_act_reg [2];
    logic [1:0] wave_reg;
    logic [1:0] wave_next;
    logic [1:0] pin_out_reg;
    logic [1:0] pin_oe_reg;
    logic [1:0] pin_own;
    logic [1:0] hit;
    logic [1:0] act_f [2];
    logic tick;

    tick_prescaler #(.PRESC_W(PRESC_W)) u_presc (
        .mclk(mclk),
        .rst(rst),
        .tick_source_sel(ctl_b_reg[2:0]),
        .ext_tick_pin(ext_tick_pin),
        .tick_enable(tick)
    );

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    wire [2:0] wave_mode_sel = {ctl_b_reg[timer8_pkg::F_MSB], ctl_a_reg[1:0]};
    wire wave_mode_msb = wave_mode_sel[2];
    wire is_fast = wave_mode_sel == timer8_pkg::MODE_FAST_FF
        || wave_mode_sel == timer8_pkg::MODE_FAST_CMP;
    wire is_pc = wave_mode_sel == timer8_pkg::MODE_PC_FF
        || wave_mode_sel == timer8_pkg::MODE_PC_CMP;
    wire is_ctc = wave_mode_sel == timer8_pkg::MODE_CTC;
    wire is_nonpwm = is_ctc || wave_mode_sel == timer8_pkg::MODE_NORMAL;
    // top from compare A in modes 2, 5 and 7
    wire top_cmp = is_ctc || wave_mode_sel == timer8_pkg::MODE_PC_CMP
        || wave_mode_sel == timer8_pkg::MODE_FAST_CMP;
    wire [7:0] top_val = top_cmp ? cmp_act_reg[0] : timer8_pkg::COUNT_MAX;
    wire at_top = count_reg == top_val;
    wire at_bottom = count_reg == timer8_pkg::COUNT_BOTTOM;
    wire wrap = tick && at_top && (is_fast || is_ctc);
    wire pc_top = tick && is_pc && at_top && !down_reg;

    // ----------------------------------------------------------------
    // counter sequence, single or dual slope
    // ----------------------------------------------------------------
    assign down_next = is_pc && (down_reg ? !at_bottom : at_top);
    // reserved modes 4 and 6 simply count like normal mode
    assign count_next = is_pc
        ? ((down_reg ? at_bottom : !at_top) ? count_reg + 8'h01 : count_reg - 8'h01)
        : (wrap ? timer8_pkg::COUNT_BOTTOM : count_reg + 8'h01);

    // overflow moment per mode
    wire ovf_set = tick && (is_pc ? at_bottom
        : wave_mode_sel == timer8_pkg::MODE_FAST_CMP ? at_top
        : count_reg == timer8_pkg::COUNT_MAX);

    // compare buffers take effect at top, bottom or at once
    wire cmp_load = is_fast ? wrap : is_pc ? pc_top : 1'b1;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire bus_req = read || write;
    wire bus_done = bus_req && !waitreq_reg;
    wire do_wr = write && !waitreq_reg && byteenable[0];
    wire [7:0] wbyte = writedata[7:0];
    wire wr_ctl_a = do_wr && address == timer8_pkg::OFF_CTL_A;
    wire wr_ctl_b = do_wr && address == timer8_pkg::OFF_CTL_B;
    wire wr_count = do_wr && address == timer8_pkg::OFF_COUNT;
    wire wr_flags = do_wr && address == timer8_pkg::OFF_FLAGS;
    wire wr_port = do_wr && address == timer8_pkg::OFF_PORT;
    wire [1:0] wr_cmp = {do_wr && address == timer8_pkg::OFF_CMP_B,
        do_wr && address == timer8_pkg::OFF_CMP_A};
    // unmapped addresses read zero and ignore writes
    wire [7:0] rd_byte =
        address == timer8_pkg::OFF_CTL_A ? ctl_a_reg & timer8_pkg::CTL_A_WMASK
        : address == timer8_pkg::OFF_CTL_B ? ctl_b_reg & timer8_pkg::CTL_B_WMASK
        : address == timer8_pkg::OFF_COUNT ? count_reg
        : address == timer8_pkg::OFF_CMP_A ? cmp_buf_reg[0]
        : address == timer8_pkg::OFF_CMP_B ? cmp_buf_reg[1]
        : address == timer8_pkg::OFF_FLAGS ? {5'h00, flags_reg}
        : address == timer8_pkg::OFF_PORT ? {4'h0, port_reg}
        : timer8_pkg::BYTE_ZERO;

    // flags: hardware set wins over any clear in the same cycle
    wire [2:0] flag_set = {hit[1], hit[0], ovf_set};
    wire [2:0] flag_clr = {vec_ack_b, vec_ack_a, vec_ack_ovf}
        | (wr_flags ? wbyte[2:0] : 3'h0);
    assign flags_next = (flags_reg & ~flag_clr) | flag_set;

    // ----------------------------------------------------------------
    // waveform action per channel
    // ----------------------------------------------------------------
    function automatic logic wave_step(input logic [1:0] act, input logic cur,
            input logic hit_q, input logic cmp_top, input logic toggle_ok);
        logic v;
        v = cur;
        if (is_nonpwm) begin
            if (hit_q && act != timer8_pkg::ACT_OFF) begin
                v = act == timer8_pkg::ACT_TOGGLE ? !cur : act[0];
            end
        end else if (is_fast || is_pc) begin
            if (act == timer8_pkg::ACT_TOGGLE) begin
                // B has no toggle here, the code is reserved
                if (hit_q && toggle_ok && wave_mode_msb) begin
                    v = !cur;
                end
            end else if (act[1]) begin
                if (is_fast) begin
                    if (hit_q && !cmp_top) begin
                        v = act[0];
                    end
                    if (wrap) begin
                        v = !act[0];
                    end
                end else if (cmp_top) begin
                    if (pc_top) begin
                        v = !act[0];
                    end
                end else if (hit_q) begin
                    v = down_reg ? !act[0] : act[0];
                end
            end
        end
        return v;
    endfunction : wave_step

    assign act_f[0] = ctl_a_reg[timer8_pkg::F_ACT_A +: 2];
    assign act_f[1] = ctl_a_reg[timer8_pkg::F_ACT_B +: 2];

    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        // a count write suppresses the match on the following tick
        assign hit[ch] = tick && !block_reg && count_reg == cmp_act_reg[ch];
        // a process, not an assign, so that mode and edge signals read inside the
        // function also wake the step, not just its arguments
        always_comb begin
            wave_next[ch] = wave_step(act_f[ch], wave_reg[ch], hit[ch],
                cmp_act_reg[ch] == top_val, ch == 0);
        end
        // pwm code 01 keeps the port pin unless channel A may toggle
        assign pin_own[ch] = act_f[ch] != timer8_pkg::ACT_OFF
            && !(act_f[ch] == timer8_pkg::ACT_TOGGLE && (is_fast || is_pc)
            && !(ch == 0 && wave_mode_msb));

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                cmp_buf_reg[ch] <= timer8_pkg::BYTE_ZERO;
                cmp_act_reg[ch] <= timer8_pkg::BYTE_ZERO;
                wave_reg[ch] <= 1'b0;
                pin_out_reg[ch] <= 1'b0;
                pin_oe_reg[ch] <= 1'b0;
            end else begin
                if (wr_cmp[ch]) begin
                    cmp_buf_reg[ch] <= wbyte;
                end
                if (cmp_load) begin
                    cmp_act_reg[ch] <= cmp_buf_reg[ch];
                end
                wave_reg[ch] <= wave_next[ch];
                // waveform takes the pin when its action is nonzero, save pwm code 01 unless channel A may toggle
                pin_out_reg[ch] <= pin_own[ch]
                    ? wave_next[ch] : port_reg[timer8_pkg::PRT_DAT + ch];
                pin_oe_reg[ch] <= port_reg[timer8_pkg::PRT_DIR + ch];
            end
        end
    end

    // ----------------------------------------------------------------
    // control, counter and bus registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctl_a_reg <= timer8_pkg::CTL_A_RST;
            ctl_b_reg <= timer8_pkg::CTL_B_RST;
            port_reg <= 4'h0;
            flags_reg <= 3'h0;
            count_reg <= timer8_pkg::COUNT_BOTTOM;
            down_reg <= 1'b0;
            block_reg <= 1'b0;
        end else begin
            if (wr_ctl_a) begin
                ctl_a_reg <= wbyte & timer8_pkg::CTL_A_WMASK;
            end
            if (wr_ctl_b) begin
                ctl_b_reg <= wbyte & timer8_pkg::CTL_B_WMASK;
            end
            if (wr_port) begin
                port_reg <= wbyte[3:0];
            end
            flags_reg <= flags_next;
            // counter moves only on enabled edges, software write wins
            if (wr_count) begin
                count_reg <= wbyte;
                down_reg <= down_reg;
                block_reg <= 1'b1;
            end else if (tick) begin
                count_reg <= count_next;
                down_reg <= down_next;
                block_reg <= 1'b0;
            end
        end
    end

    // one wait state per access, answer in the second cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            waitreq_reg <= 1'b1;
            readdata_reg <= 32'h0000_0000;
        end else begin
            waitreq_reg <= !(bus_req && waitreq_reg);
            if (read && waitreq_reg) begin
                readdata_reg <= {24'h00_0000, rd_byte};
            end
        end
    end

    assign readdata = readdata_reg;
    assign waitrequest = waitreq_reg;
    assign overflow_flag = flags_reg[timer8_pkg::FLG_OVF];
    assign match_flag_a = flags_reg[timer8_pkg::FLG_A];
    assign match_flag_b = flags_reg[timer8_pkg::FLG_B];
    assign wave_out_a = wave_reg[0];
    assign wave_out_b = wave_reg[1];
    assign pin_a_out = pin_out_reg[0];
    assign pin_a_oe = pin_oe_reg[0];
    assign pin_b_out = pin_out_reg[1];
    assign pin_b_oe = pin_oe_reg[1];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence rd_ctl_a_s;
        read && waitreq_reg && address == timer8_pkg::OFF_CTL_A;
    endsequence

    sequence fast_wrap_s;
        tick && wave_mode_sel == timer8_pkg::MODE_FAST_FF && at_top
            && act_f[0] == timer8_pkg::ACT_CLEAR;
    endsequence

    ctl_a_reserved_a: assert property (rd_ctl_a_s |=> !waitreq_reg ##0 readdata[3:2] == 2'h0)
        else $error("control A reserved bits read nonzero");
    count_tick_only_a: assert property (!tick && !wr_count |=> $stable(count_reg))
        else $error("counter moved without a tick");
    ovf_at_max_a: assert property (tick && is_nonpwm && count_reg == timer8_pkg::COUNT_MAX
        |=> overflow_flag)
        else $error("overflow flag missed at max");
    match_flag_a_a: assert property (hit[0] |=> match_flag_a)
        else $error("match flag A not set after match");
    pin_enable_a: assert property (##1 pin_a_oe == $past(port_reg[timer8_pkg::PRT_DIR]))
        else $error("pin A driver does not follow direction");
    fast_bottom_set_a: assert property (fast_wrap_s |=> wave_out_a
        ##0 count_reg == timer8_pkg::COUNT_BOTTOM)
        else $error("fast PWM output not set at bottom");
    toggle_nonpwm_a: assert property (hit[0] && is_nonpwm && act_f[0] == timer8_pkg::ACT_TOGGLE
        |=> wave_out_a != $past(wave_out_a))
        else $error("output A did not toggle on match");
    pc_turn_a: assert property (pc_top && !wr_count |=> down_reg [*1] ##1 1'b1)
        else $error("phase-correct count did not turn at top");
    bus_answer_a: assert property (bus_req && waitreq_reg && !$past(bus_done)
        |=> !waitrequest)
        else $error("bus answer not given one cycle after request");

endmodule : timer8_waveform_mode_control

// ### testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic mclk, rst, read, write, ext_tick_pin, vec_ack_ovf, vec_ack_a, vec_ack_b;
    logic [7:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [3:0] byteenable;
    logic waitrequest, overflow_flag, match_flag_a, match_flag_b, wave_out_a, wave_out_b;
    logic pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
    int error_cnt, comparisons;

    timer8_waveform_mode_control #(.PRESC_W(10)) uut (
        .mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .ext_tick_pin(ext_tick_pin), .vec_ack_ovf(vec_ack_ovf),
        .vec_ack_a(vec_ack_a), .vec_ack_b(vec_ack_b), .overflow_flag(overflow_flag),
        .match_flag_a(match_flag_a), .match_flag_b(match_flag_b), .wave_out_a(wave_out_a),
        .wave_out_b(wave_out_b), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
        .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe));

    // 10 MHz clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task end_sim;
        if (error_cnt == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // one avalon access; the request stands until waitrequest is sampled low
    task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge mclk);
        address <= a;
        writedata <= {24'h000000, d};
        write <= wr;
        read <= ~wr;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (waitrequest === 1'b0) break;
        end
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (i == 20) begin
            error_cnt++;
            end_sim;
        end
    endtask : bus

    task wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(nm, rd, {24'h000000, exp});
    endtask : rdc

    // stop, load compares and count, start; compares are buffered in pwm modes,
    // so several counter periods pass before anything is judged
    task cfg(input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] ma,
             input logic [7:0] mb);
        wr(timer8_pkg::OFF_CTL_B, 8'h00);
        wr(timer8_pkg::OFF_CMP_A, ma);
        wr(timer8_pkg::OFF_CMP_B, mb);
        wr(timer8_pkg::OFF_COUNT, 8'h00);
        wr(timer8_pkg::OFF_CTL_A, ca);
        wr(timer8_pkg::OFF_CTL_B, cb);
        repeat (1100) @(posedge mclk);
        wr(timer8_pkg::OFF_FLAGS, 8'h07);
    endtask : cfg

    // cycles high over whole waveform periods, a few cycles of slack for edges
    task duty(input string nm, input logic chb, input int n, input int exp);
        int cnt;
        cnt = 0;
        repeat (n) begin
            @(posedge mclk);
            cnt += chb ? int'(wave_out_b) : int'(wave_out_a);
        end
        check(nm, (cnt > exp - 7 && cnt < exp + 7) ? exp : cnt, exp);
    endtask : duty

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_regs;
        rdc("ctl_a reset", timer8_pkg::OFF_CTL_A, 8'h00);
        check("wave a reset", wave_out_a, 1'b0);
        wr(timer8_pkg::OFF_CTL_A, 8'hFF);
        rdc("ctl_a reserved", timer8_pkg::OFF_CTL_A, 8'hF3);
        rdc("unmapped", 8'h4C, 8'h00);
        wr(timer8_pkg::OFF_CTL_A, 8'h00);
    endtask : t_regs

    task t_nonpwm;
        wr(timer8_pkg::OFF_PORT, 8'h03);
        cfg(8'hF0, 8'h01, 8'h10, 8'h20);
        repeat (300) @(posedge mclk);
        check("set a", wave_out_a, 1'b1);
        check("set b", wave_out_b, 1'b1);
        check("pin a", pin_a_out, 1'b1);
        check("oe a", pin_a_oe, 1'b1);
        check("flag a", match_flag_a, 1'b1);
        check("ovf normal", overflow_flag, 1'b1);
        wr(timer8_pkg::OFF_CTL_B, 8'h00);
        @(posedge mclk);
        vec_ack_a <= 1'b1;
        @(posedge mclk);
        vec_ack_a <= 1'b0;
        repeat (2) @(posedge mclk);
        check("ack a", match_flag_a, 1'b0);
        wr(timer8_pkg::OFF_FLAGS, 8'h07);
        rdc("flags w1c", timer8_pkg::OFF_FLAGS, 8'h00);
        cfg(8'hA0, 8'h01, 8'h10, 8'h20);
        repeat (300) @(posedge mclk);
        check("clr a", wave_out_a, 1'b0);
        check("clr b", wave_out_b, 1'b0);
        cfg(8'h50, 8'h01, 8'h10, 8'h20);
        duty("tgl a", 1'b0, 512, 256);
        duty("tgl b", 1'b1, 512, 256);
        wr(timer8_pkg::OFF_CTL_A, 8'h00);
        wr(timer8_pkg::OFF_PORT, 8'h04);
        repeat (3) @(posedge mclk);
        check("port a", pin_a_out, 1'b1);
        check("oe off", pin_a_oe, 1'b0);
    endtask : t_nonpwm

    task t_pwm;
        cfg(8'h83, 8'h01, 8'h80, 8'h00);
        duty("fast noninv", 1'b0, 512, 258);
        cfg(8'hC3, 8'h01, 8'h80, 8'h00);
        duty("fast inv", 1'b0, 512, 254);
        cfg(8'h83, 8'h01, 8'hFF, 8'h00);
        duty("fast top", 1'b0, 512, 512);
        cfg(8'h23, 8'h01, 8'h00, 8'h80);
        duty("fast b", 1'b1, 512, 258);
        cfg(8'hE1, 8'h01, 8'h40, 8'h40);
        duty("pc inv a", 1'b0, 510, 382);
        duty("pc b", 1'b1, 510, 128);
        cfg(8'hA1, 8'h01, 8'hFF, 8'hFF);
        duty("pc top a", 1'b0, 510, 510);
        duty("pc top b", 1'b1, 510, 510);
        cfg(8'h63, 8'h09, 8'h3F, 8'h1F);
        duty("fast7 tgl", 1'b0, 256, 128);
        duty("fast7 b", 1'b1, 256, 128);
        check("ovf top", overflow_flag, 1'b1);
        cfg(8'h43, 8'h01, 8'h10, 8'h00);
        wr(timer8_pkg::OFF_PORT, 8'h07);
        repeat (3) @(posedge mclk);
        check("pwm 01 off", pin_a_out, 1'b1);
        cfg(8'h42, 8'h01, 8'h0F, 8'h05);
        duty("ctc tgl", 1'b0, 320, 160);
        check("ctc no ovf", overflow_flag, 1'b0);
        check("ctc flag", match_flag_a, 1'b1);
        cfg(8'h83, 8'h02, 8'h80, 8'h00);
        repeat (4200) @(posedge mclk);
        duty("div8", 1'b0, 4096, 2064);
    endtask : t_pwm

    // reset again in mid-run, control A must come back to zero
    task t_reset;
        wr(timer8_pkg::OFF_CTL_A, 8'hA1);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rdc("ctl_a mid reset", timer8_pkg::OFF_CTL_A, 8'h00);
        check("wave b reset", wave_out_b, 1'b0);
    endtask : t_reset

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        error_cnt = 0;
        comparisons = 0;
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h00000000;
        byteenable = 4'h1;
        ext_tick_pin = 1'b0;
        vec_ack_ovf = 1'b0;
        vec_ack_a = 1'b0;
        vec_ack_b = 1'b0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        t_regs;
        t_nonpwm;
        t_pwm;
        t_reset;
        end_sim;
    end
endmodule : testbench
